// >>> core/csb_pkg.sv
// Constants and carrier types for the core status register and banked data map.
package csb_pkg;
	// Data memory address split: five bank bits above seven offset bits.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned OFF_W = 7;
	localparam int unsigned BANK_W = 5;
	// Offsets inside every bank.
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_PTR_LO = 7'h04;
	localparam logic [6:0] OFF_PTR_HI = 7'h05;
	localparam logic [6:0] OFF_BANK_SEL = 7'h08;
	localparam logic [6:0] OFF_CORE_LAST = 7'h0b;
	localparam logic [6:0] OFF_PERIPH_LAST = 7'h1f;
	localparam logic [6:0] OFF_GPR_FIRST = 7'h20;
	localparam logic [6:0] OFF_GPR_LAST = 7'h6f;
	localparam logic [6:0] OFF_COMMON_FIRST = 7'h70;
	// General purpose RAM sizing and its linear window seen through the pointer.
	localparam logic [9:0] GPR_PER_BANK = 10'h050;
	localparam logic [4:0] GPR_BANKS = 5'h08;
	localparam logic [9:0] GPR_TOTAL = 10'h280;
	localparam int unsigned COMMON_BYTES = 16;
	localparam logic [15:0] LIN_BASE = 16'h2000;
	// Status register bit positions.
	localparam int unsigned BIT_WDT = 4;
	localparam int unsigned BIT_SLEEP = 3;
	localparam int unsigned BIT_Z = 2;
	localparam int unsigned BIT_DC = 1;
	localparam int unsigned BIT_C = 0;
	// Reset values after power-on or brown-out.
	localparam logic RST_CAUSE_FLAG = 1'h1;
	localparam logic RST_ARITH_FLAG = 1'h0;
	localparam logic [4:0] RST_BANK = 5'h00;
	localparam logic [7:0] RST_PTR = 8'h00;

	// One flag update request from the instruction execution logic.
	typedef struct packed {
		logic valid;
		logic aff_z;
		logic aff_dc;
		logic aff_c;
		logic use_adder;
		logic subtract;
		logic [7:0] op_a;
		logic [7:0] op_b;
		logic [7:0] logic_result;
	} csb_alu_t;

	// Watchdog and power events, each a one-cycle pulse.
	typedef struct packed {
		logic wdt_timeout;
		logic watchdog_clear_instr;
		logic sleep_instr;
	} csb_evt_t;
endpackage : csb_pkg

// >>> core/csb_core.sv
// Core status register, core pointer registers and banked data memory decode.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Status bits seven to five read zero.
// - Timeout flag set by power-up, clear, sleep.
// - Watchdog timeout clears the timeout flag.
// - Power-down flag set by power-up or clear.
// - Sleep instruction clears the power-down flag.
// - Zero flag follows a zero result.
// - Digit carry is carry out of bit three.
// - Carry is carry out of the top bit.
// - Subtraction carries mean no borrow.
// - Subtract adds the second operand's complement.
// - Cause flags read-only; arithmetic flags reset on power-on.
// - Peripheral space follows core registers in each bank.
// - Up to eighty RAM bytes per bank.
// - Sixteen common bytes shared by all banks.
// - Pointer reaches RAM as one linear space.
// - Flag-affecting instruction blocks direct flag write.
// - Unimplemented locations read as zero.
// - Twelve-bit address: five bank, seven offset bits.
// - Core registers in first twelve offsets everywhere.
module csb_core (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic por_in,
	input wire logic [11:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire csb_pkg::csb_alu_t alu_in,
	input wire csb_pkg::csb_evt_t evt_in,
	output logic [7:0] status_out,
	output logic [4:0] bank_sel_out,
	output logic periph_wr_out,
	output logic periph_rd_out,
	output logic [11:0] periph_addr_out,
	output logic [7:0] periph_wdata_out,
	input wire logic [7:0] periph_rdata_in
);
	logic flag_wdt, flag_sleep, flag_z, flag_dc, flag_c;
	logic next_wdt, next_sleep, next_z, next_dc, next_c;
	logic [4:0] bank_sel, next_bank_sel;
	logic [7:0] ptr_lo, ptr_hi, next_ptr_lo, next_ptr_hi;
	logic [7:0] rdata, next_rdata;
	logic [7:0] gpr_mem [0:639];
	logic [7:0] common_mem [0:15];
	logic [15:0] ptr;
	logic [15:0] lin_off;
	logic [11:0] eff_addr;
	logic eff_ok, via_ptr;
	logic [4:0] eff_bank;
	logic [6:0] eff_off;
	logic is_core, is_periph, is_gpr, is_common;
	logic [9:0] gpr_idx;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] b_eff;
	logic [7:0] result;
	logic gpr_wr, common_wr, status_wr;

	// The pointer forms one 16-bit address; the linear window hides the bank gaps.
	always_comb begin
		ptr = {ptr_hi, ptr_lo};
		lin_off = ptr - csb_pkg::LIN_BASE;
		via_ptr = (addr_in[6:0] == csb_pkg::OFF_INDIRECT);
		eff_addr = addr_in;
		eff_ok = 1'b1;
		if (via_ptr) begin
			if (ptr[15:12] == 4'h0) begin
				eff_addr = ptr[11:0];
				eff_ok = (ptr[6:0] != csb_pkg::OFF_INDIRECT);
			end else if (ptr >= csb_pkg::LIN_BASE && lin_off < 16'(csb_pkg::GPR_TOTAL)) begin
				eff_addr[11:7] = 5'(lin_off[9:0] / csb_pkg::GPR_PER_BANK);
				eff_addr[6:0] = 7'(lin_off[9:0] % csb_pkg::GPR_PER_BANK) + csb_pkg::OFF_GPR_FIRST;
			end else begin
				eff_ok = 1'b0;
			end
		end
	end

	// Region decode uses the offset alone, except general purpose RAM, which also needs a bank below eight.
	always_comb begin
		eff_bank = eff_addr[11:7];
		eff_off = eff_addr[6:0];
		is_core = eff_ok && eff_off <= csb_pkg::OFF_CORE_LAST;
		is_periph = eff_ok && eff_off > csb_pkg::OFF_CORE_LAST
			&& eff_off <= csb_pkg::OFF_PERIPH_LAST;
		is_gpr = eff_ok && eff_off >= csb_pkg::OFF_GPR_FIRST
			&& eff_off <= csb_pkg::OFF_GPR_LAST && eff_bank < csb_pkg::GPR_BANKS;
		is_common = eff_ok && eff_off >= csb_pkg::OFF_COMMON_FIRST;
		gpr_idx = 10'(eff_bank) * csb_pkg::GPR_PER_BANK
			+ 10'(eff_off - csb_pkg::OFF_GPR_FIRST);
	end

	// Peripheral strobes pass straight through; the peripheral answers in the same cycle.
	always_comb begin
		periph_wr_out = wr_in && is_periph;
		periph_rd_out = rd_in && is_periph;
		periph_addr_out = eff_addr;
		periph_wdata_out = wdata_in;
	end

	// Subtraction is an addition of the inverted operand plus one, so carries mean no borrow.
	always_comb begin
		b_eff = alu_in.subtract ? ~alu_in.op_b : alu_in.op_b;
		sum9 = {1'b0, alu_in.op_a} + {1'b0, b_eff} + {8'h00, alu_in.subtract};
		nib5 = {1'b0, alu_in.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_in.subtract};
		result = alu_in.use_adder ? sum9[7:0] : alu_in.logic_result;
	end

	// Status, bank select and pointer next values.
	always_comb begin
		status_wr = wr_in && is_core && eff_off == csb_pkg::OFF_STATUS;
		next_wdt = flag_wdt;
		next_sleep = flag_sleep;
		next_z = flag_z;
		next_dc = flag_dc;
		next_c = flag_c;
		next_bank_sel = bank_sel;
		next_ptr_lo = ptr_lo;
		next_ptr_hi = ptr_hi;
		// Direct write reaches only the arithmetic flags; cause flags are read-only.
		// Any flag-affecting instruction blocks all three, so unaffected flags stay put.
		if (status_wr && !(alu_in.valid
			&& (alu_in.aff_z || alu_in.aff_dc || alu_in.aff_c))) begin
			next_z = wdata_in[csb_pkg::BIT_Z];
			next_dc = wdata_in[csb_pkg::BIT_DC];
			next_c = wdata_in[csb_pkg::BIT_C];
		end
		// A flag computed by the instruction overrides its own direct write.
		if (alu_in.valid) begin
			if (alu_in.aff_z) begin
				next_z = (result == 8'h00);
			end
			if (alu_in.aff_dc) begin
				next_dc = nib5[4];
			end
			if (alu_in.aff_c) begin
				next_c = sum9[8];
			end
		end
		// A clear or sleep that coincides with a timeout wins, so the set is kept.
		if (evt_in.wdt_timeout) begin
			next_wdt = 1'b0;
		end
		if (evt_in.watchdog_clear_instr) begin
			next_wdt = 1'b1;
			next_sleep = 1'b1;
		end else if (evt_in.sleep_instr) begin
			next_wdt = 1'b1;
			next_sleep = 1'b0;
		end
		if (wr_in && is_core && eff_off == csb_pkg::OFF_BANK_SEL) begin
			next_bank_sel = wdata_in[4:0];
		end
		if (wr_in && is_core && eff_off == csb_pkg::OFF_PTR_LO) begin
			next_ptr_lo = wdata_in;
		end
		if (wr_in && is_core && eff_off == csb_pkg::OFF_PTR_HI) begin
			next_ptr_hi = wdata_in;
		end
		// Power-on and brown-out set both cause flags and clear the three arithmetic flags; other resets leave all five flags alone.
		if (reset_in) begin
			next_bank_sel = csb_pkg::RST_BANK;
			next_ptr_lo = csb_pkg::RST_PTR;
			next_ptr_hi = csb_pkg::RST_PTR;
			if (por_in) begin
				next_wdt = csb_pkg::RST_CAUSE_FLAG;
				next_sleep = csb_pkg::RST_CAUSE_FLAG;
				next_z = csb_pkg::RST_ARITH_FLAG;
				next_dc = csb_pkg::RST_ARITH_FLAG;
				next_c = csb_pkg::RST_ARITH_FLAG;
			end else begin
				next_wdt = flag_wdt;
				next_sleep = flag_sleep;
				next_z = flag_z;
				next_dc = flag_dc;
				next_c = flag_c;
			end
		end
	end

	// Read mux; anything that is not backed by storage answers zero.
	always_comb begin
		next_rdata = 8'h00;
		if (rd_in && !reset_in) begin
			if (is_core) begin
				case (eff_off)
					csb_pkg::OFF_STATUS: next_rdata = status_out;
					csb_pkg::OFF_PTR_LO: next_rdata = ptr_lo;
					csb_pkg::OFF_PTR_HI: next_rdata = ptr_hi;
					csb_pkg::OFF_BANK_SEL: next_rdata = {3'h0, bank_sel};
					default: next_rdata = 8'h00;
				endcase
			end else if (is_periph) begin
				next_rdata = periph_rdata_in;
			end else if (is_gpr) begin
				next_rdata = gpr_mem[gpr_idx];
			end else if (is_common) begin
				next_rdata = common_mem[eff_off[3:0]];
			end
		end
	end

	// Status is assembled from the flags; the top three bits are constant zero.
	always_comb begin
		status_out = {3'h0, flag_wdt, flag_sleep, flag_z, flag_dc, flag_c};
		bank_sel_out = bank_sel;
		rdata_out = rdata;
		gpr_wr = wr_in && is_gpr && !reset_in;
		common_wr = wr_in && is_common && !reset_in;
	end

	// State registers only capture their next values.
	always_ff @(posedge clk_sys_in) begin
		flag_wdt <= next_wdt;
		flag_sleep <= next_sleep;
		flag_z <= next_z;
		flag_dc <= next_dc;
		flag_c <= next_c;
		bank_sel <= next_bank_sel;
		ptr_lo <= next_ptr_lo;
		ptr_hi <= next_ptr_hi;
		rdata <= next_rdata;
	end

	// RAM arrays have no reset, which keeps them mappable onto block memory.
	always_ff @(posedge clk_sys_in) begin
		if (gpr_wr) begin
			gpr_mem[gpr_idx] <= wdata_in;
		end
		if (common_wr) begin
			common_mem[eff_off[3:0]] <= wdata_in;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	sequence s_common_wr_rd;
		(wr_in && !via_ptr && addr_in[6:0] >= csb_pkg::OFF_COMMON_FIRST) ##1
		(rd_in && !via_ptr && addr_in[6:0] == $past(addr_in[6:0]));
	endsequence

	property p_status_top_zero;
		(rd_in && !via_ptr && addr_in[6:0] == csb_pkg::OFF_STATUS) |=> rdata_out[7:5] == 3'h0;
	endproperty
	a_status_top_zero: assert property (p_status_top_zero) else $error("status top bits not zero");

	property p_wdt_set;
		(evt_in.watchdog_clear_instr || evt_in.sleep_instr) |=> status_out[csb_pkg::BIT_WDT];
	endproperty
	a_wdt_set: assert property (p_wdt_set) else $error("timeout flag not set");

	property p_wdt_clear;
		(evt_in.wdt_timeout && !evt_in.watchdog_clear_instr && !evt_in.sleep_instr)
			|=> !status_out[csb_pkg::BIT_WDT];
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("timeout flag not cleared");

	property p_sleep_flags;
		(evt_in.sleep_instr && !evt_in.watchdog_clear_instr)
			|=> !status_out[csb_pkg::BIT_SLEEP] ##1 status_out[csb_pkg::BIT_SLEEP] == $past(status_out[csb_pkg::BIT_SLEEP]) || $past(evt_in.watchdog_clear_instr);
	endproperty
	a_sleep_flags: assert property (p_sleep_flags) else $error("power-down flag wrong after sleep");

	property p_clear_sets_pd;
		evt_in.watchdog_clear_instr |=> status_out[csb_pkg::BIT_SLEEP];
	endproperty
	a_clear_sets_pd: assert property (p_clear_sets_pd) else $error("power-down flag not set");

	property p_zero_logic;
		(alu_in.valid && alu_in.aff_z && !alu_in.use_adder)
			|=> status_out[csb_pkg::BIT_Z] == ($past(alu_in.logic_result) == 8'h00);
	endproperty
	a_zero_logic: assert property (p_zero_logic) else $error("zero flag wrong");

	property p_add_carries;
		(alu_in.valid && alu_in.aff_c && alu_in.aff_dc && alu_in.use_adder && !alu_in.subtract)
			|=> status_out[csb_pkg::BIT_C] == (({1'b0, $past(alu_in.op_a)}
			+ {1'b0, $past(alu_in.op_b)}) > 9'h0ff)
			&& status_out[csb_pkg::BIT_DC] == (({1'b0, $past(alu_in.op_a[3:0])}
			+ {1'b0, $past(alu_in.op_b[3:0])}) > 5'h0f);
	endproperty
	a_add_carries: assert property (p_add_carries) else $error("add carries wrong");

	property p_sub_borrow;
		(alu_in.valid && alu_in.aff_c && alu_in.use_adder && alu_in.subtract)
			|=> status_out[csb_pkg::BIT_C] == ($past(alu_in.op_a) >= $past(alu_in.op_b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

	property p_flags_hold;
		(!alu_in.valid && !status_wr) |=> status_out[2:0] == $past(status_out[2:0]);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("arithmetic flags changed");

	property p_write_blocked;
		(status_wr && alu_in.valid && alu_in.aff_z && !alu_in.aff_dc && !alu_in.aff_c)
			|=> status_out[1:0] == $past(status_out[1:0]);
	endproperty
	a_write_blocked: assert property (p_write_blocked)
		else $error("direct flag write not blocked");

	property p_common_shared;
		s_common_wr_rd |=> rdata_out == $past(wdata_in, 2);
	endproperty
	a_common_shared: assert property (p_common_shared) else $error("common RAM not shared");

	property p_unimpl_zero;
		(rd_in && !via_ptr && addr_in[11:7] >= csb_pkg::GPR_BANKS
			&& addr_in[6:0] >= csb_pkg::OFF_GPR_FIRST && addr_in[6:0] <= csb_pkg::OFF_GPR_LAST)
			|=> rdata_out == 8'h00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero");
endmodule : csb_core

`default_nettype wire

// >>> testbench/csb_periph_model.sv
// Peripheral register stub that answers the core's passthrough strobes.
`timescale 1ns/10ps
`default_nettype none
module csb_periph_model (
	input wire logic clk_sys_in,
	input wire logic periph_wr_in,
	input wire logic periph_rd_in,
	input wire logic [11:0] periph_addr_in,
	input wire logic [7:0] periph_wdata_in,
	output logic [7:0] periph_rdata_out
);
	logic [7:0] regs [0:255];
	logic [7:0] last;
	logic [7:0] idx;
	// The low three bank bits and low five offset bits pick one stub byte, so banks eight apart share a slot.
	assign idx = {periph_addr_in[9:7], periph_addr_in[4:0]};
	// Writes are stored and the last driven value is remembered.
	always_ff @(posedge clk_sys_in) begin
		if (periph_wr_in) begin
			regs[idx] <= periph_wdata_in;
		end
		last <= periph_rdata_out;
	end
	// Outside a read the bus shows the inverse of its last value, so a late sample sees junk.
	always_comb begin
		periph_rdata_out = periph_rd_in ? regs[idx] : ~last;
	end
endmodule : csb_periph_model
`default_nettype wire

// >>> testbench/csb_core_tb.sv
// Self-checking bench for the core status register and banked data map.
`timescale 1ns/10ps
`default_nettype none
module csb_core_tb;
	logic clk_sys_in;
	logic reset_in;
	logic por_in;
	logic wr_in;
	logic rd_in;
	logic [11:0] addr_in;
	logic [7:0] wdata_in;
	logic [7:0] rdata_out;
	logic [7:0] status_out;
	logic [4:0] bank_sel_out;
	logic pwr;
	logic prd;
	logic [11:0] paddr;
	logic [7:0] pwdata;
	logic [7:0] prdata;
	csb_pkg::csb_alu_t alu_in;
	csb_pkg::csb_evt_t evt_in;
	int bad_count;
	int samples_checked;
	int cyc = 0;

	// Free-running 50 MHz clock.
	always #10 clk_sys_in = ~clk_sys_in;

	csb_core csb_core_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .por_in(por_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .alu_in(alu_in), .evt_in(evt_in), .status_out(status_out),
		.bank_sel_out(bank_sel_out), .periph_wr_out(pwr), .periph_rd_out(prd),
		.periph_addr_out(paddr), .periph_wdata_out(pwdata), .periph_rdata_in(prdata));

	csb_periph_model csb_periph_model_inst (.clk_sys_in(clk_sys_in), .periph_wr_in(pwr),
		.periph_rd_in(prd), .periph_addr_in(paddr), .periph_wdata_in(pwdata),
		.periph_rdata_out(prdata));

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// Compares one byte with case equality so an unknown never matches.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One-cycle write strobe; the strobe drops after the taking edge.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data are only valid in the following cycle.
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask : rd

	// Flag update; m is {aff_z, aff_dc, aff_c, use_adder, subtract}.
	task automatic op(input logic [4:0] m, input logic [7:0] a, b, l, e);
		@(posedge clk_sys_in);
		alu_in <= {1'b1, m, a, b, l};
		@(posedge clk_sys_in);
		alu_in.valid <= 1'b0;
		#1 chk(status_out, e);
	endtask : op

	// Event pulse; v is {timeout, clear, sleep}.
	task automatic ev(input logic [2:0] v, input logic [7:0] e);
		@(posedge clk_sys_in);
		evt_in <= v;
		@(posedge clk_sys_in);
		evt_in <= 3'h0;
		#1 chk(status_out, e);
	endtask : ev

	// Holds reset for five cycles with the given cause qualifier.
	task automatic rst(input logic p);
		@(posedge clk_sys_in);
		reset_in <= 1'b1;
		por_in <= p;
		repeat (5) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		#1;
	endtask : rst

	// A hang is cut short here and counted as a mismatch.
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			end_sim();
		end
	end

	// Main sequence: flags, events, resets, then the memory map.
	initial begin
		clk_sys_in = 1'b0;
		reset_in = 1'b1;
		por_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 12'h000;
		wdata_in = 8'h00;
		alu_in = '0;
		evt_in = '0;
		rst(1'b1);
		chk(status_out, 8'h18);
		wr(12'h003, 8'hff);
		rd(12'h003, 8'h1f);
		op(5'b11110, 8'h0f, 8'h01, 8'h00, 8'h1a);
		op(5'b11110, 8'hff, 8'h01, 8'h00, 8'h1f);
		op(5'b11111, 8'h00, 8'h01, 8'h00, 8'h18);
		op(5'b11111, 8'h05, 8'h05, 8'h00, 8'h1f);
		op(5'b11111, 8'h10, 8'h01, 8'h00, 8'h19);
		op(5'b10000, 8'h00, 8'h00, 8'h00, 8'h1d);
		op(5'b00110, 8'h01, 8'h01, 8'h00, 8'h1c);
		op(5'b00010, 8'hff, 8'hff, 8'h00, 8'h1c);
		// Direct write and a zero-flag update land on the same edge.
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= 12'h003;
		wdata_in <= 8'h03;
		alu_in <= {1'b1, 5'b10000, 24'h000000};
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		alu_in.valid <= 1'b0;
		#1 chk(status_out, 8'h1c);
		ev(3'b001, 8'h14);
		ev(3'b100, 8'h04);
		// Cause flags are now zero, so a write of ones shows they are read-only.
		wr(12'h003, 8'hff);
		rd(12'h003, 8'h07);
		rst(1'b0);
		chk(status_out, 8'h07);
		ev(3'b010, 8'h1f);
		rd(12'h583, 8'h1f);
		// Write and read back to back from two banks through the common bytes.
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= 12'h070;
		wdata_in <= 8'ha5;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= 12'h3f0;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, 8'ha5);
		wr(12'h0a0, 8'h3c);
		rd(12'h0a0, 8'h3c);
		rd(12'h420, 8'h00);
		rd(12'h009, 8'h00);
		wr(12'h104, 8'h50);
		wr(12'h285, 8'h20);
		rd(12'h000, 8'h3c);
		wr(12'h000, 8'h77);
		rd(12'h0a0, 8'h77);
		wr(12'h108, 8'h1f);
		#1 chk({3'h0, bank_sel_out}, 8'h1f);
		rd(12'h088, 8'h1f);
		wr(12'h20c, 8'h5a);
		wr(12'h220, 8'h11);
		rd(12'h20c, 8'h5a);
		rd(12'h220, 8'h11);
		end_sim();
	end
endmodule : csb_core_tb
`default_nettype wire
